// ===== dpd_params.svh
`ifndef DPD_PARAMS_SVH
`define DPD_PARAMS_SVH

// Clock and exit-delay timing.
`define DPD_CLK_NS 20
`define DPD_EXIT_UNIT_NS 1000
`define DPD_EXIT_UNIT_CODE 2'b01
`define DPD_EXIT_COUNT 5'b11101
`define DPD_EXIT_DELAY_NS ((`DPD_EXIT_COUNT + 1) * `DPD_EXIT_UNIT_NS)
`define DPD_EXIT_CYCLES (`DPD_EXIT_DELAY_NS / `DPD_CLK_NS)

// Instruction codes.
`define DPD_CMD_ENTER 8'hB9
`define DPD_CMD_EXIT 8'hAB
`define DPD_CMD_STATUS 8'h05
`define DPD_CMD_SFDP 8'h5A

// Descriptor word fields, most significant field first.
`define DPD_SUPPORTED_BIT 1'b0
`define DPD_RSVD_HI 4'hF
`define DPD_POLL_LEGACY 2'b01
`define DPD_RSVD_LO 2'b11
`define DPD_DESC_WORD {`DPD_SUPPORTED_BIT, `DPD_CMD_ENTER, `DPD_CMD_EXIT, `DPD_EXIT_UNIT_CODE, \
   `DPD_EXIT_COUNT, `DPD_RSVD_HI, `DPD_POLL_LEGACY, `DPD_RSVD_LO}
`define DPD_BPT_BASE 24'h000080
`define DPD_WORD14_OFS 24'h000034
`define DPD_BLANK_BYTE 8'hFF

// Register map.
`define DPD_REG_CTRL 12'h000
`define DPD_REG_STATUS 12'h004
`define DPD_REG_DESC 12'h008
`define DPD_CTRL_BUSY 0
`define DPD_ST_DPD 0
`define DPD_ST_EXITWAIT 1
`define DPD_ST_BUSY 2

`endif

// ===== dpd_pkg.sv
package dpd_pkg;
   typedef enum logic [2:0] {
      PH_CMD = 3'b000,
      PH_ADDR = 3'b001,
      PH_DUMMY = 3'b010,
      PH_DATA = 3'b011,
      PH_SKIP = 3'b100
   } dpd_phase_t;
endpackage

// ===== dpd_sfdp_power.sv
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dpd_params.svh"

module dpd_sfdp_power
   import dpd_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial link.
   input wire logic sclk,
   input wire logic csB,
   input wire logic mosi,
   output logic miso,
   output logic misoOe,
   // Power state.
   output logic deepPowerDown
);

   logic sclkS1, sclkS2, sclkD;
   logic csS1, csS2, csD;
   logic mosiS1, mosiS2;
   logic sclkRise, sclkFall, csRise;
   dpd_phase_t ph;
   logic [4:0] bitCnt;
   logic [7:0] shiftIn;
   logic [7:0] cmd;
   logic cmdValid;
   logic [23:0] addr;
   logic [7:0] txShift;
   logic loadTx;
   logic [7:0] txByte;
   logic [7:0] nextByteIn;
   logic exitWait;
   logic [10:0] waitCnt;
   logic busyFlag;
   logic apbAccess;

   // Byte of the parameter table at a byte address; unlisted bytes read blank.
   function automatic logic [7:0] sfdpByte(input logic [23:0] a);
      logic [23:0] rel;
      logic [31:0] word;
      rel = a - `DPD_BPT_BASE;
      word = `DPD_DESC_WORD;
      if (rel[23:2] == 22'(`DPD_WORD14_OFS >> 2)) begin
         sfdpByte = word[rel[1:0]*8 +: 8];
      end else begin
         sfdpByte = `DPD_BLANK_BYTE;
      end
   endfunction

   // Link pins cross into the clock domain through two flip-flops each.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         {sclkS1, sclkS2, sclkD} <= 3'h0;
         {csS1, csS2, csD} <= 3'h7;
         {mosiS1, mosiS2} <= 2'h0;
      end else begin
         sclkS1 <= sclk;
         sclkS2 <= sclkS1;
         sclkD <= sclkS2;
         csS1 <= csB;
         csS2 <= csS1;
         csD <= csS2;
         mosiS1 <= mosi;
         mosiS2 <= mosiS1;
      end
   end

   assign sclkRise = sclkS2 & ~sclkD & ~csS2;
   assign sclkFall = ~sclkS2 & sclkD & ~csS2;
   assign csRise = csS2 & ~csD;
   assign nextByteIn = {shiftIn[6:0], mosiS2};

   // Frame decoder.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ph <= PH_CMD;
         bitCnt <= 5'h00;
         shiftIn <= 8'h00;
         cmd <= 8'h00;
         cmdValid <= 1'b0;
         addr <= 24'h000000;
      end else if (csS2) begin
         ph <= PH_CMD;
         bitCnt <= 5'h00;
         cmdValid <= 1'b0;
      end else if (sclkRise) begin
         bitCnt <= bitCnt + 5'h01;
         cmdValid <= (ph == PH_CMD) && (bitCnt == 5'h07);
         case (ph)
            PH_CMD: begin
               shiftIn <= nextByteIn;
               if (bitCnt == 5'h07) begin
                  cmd <= nextByteIn;
                  bitCnt <= 5'h00;
                  if (deepPowerDown || exitWait) begin
                     ph <= PH_SKIP;
                  end else if (nextByteIn == `DPD_CMD_SFDP) begin
                     ph <= PH_ADDR;
                  end else if (nextByteIn == `DPD_CMD_STATUS) begin
                     ph <= PH_DATA;
                  end else begin
                     ph <= PH_SKIP;
                  end
               end
            end
            PH_ADDR: begin
               addr <= {addr[22:0], mosiS2};
               if (bitCnt == 5'h17) begin
                  ph <= PH_DUMMY;
                  bitCnt <= 5'h00;
               end
            end
            PH_DUMMY: begin
               if (bitCnt == 5'h07) begin
                  ph <= PH_DATA;
                  bitCnt <= 5'h00;
               end
            end
            PH_DATA: begin
               if (bitCnt == 5'h07) begin
                  bitCnt <= 5'h00;
                  addr <= addr + 24'h000001;
               end
            end
            PH_SKIP: begin
               bitCnt <= 5'h00;
            end
            default: begin
               ph <= PH_SKIP;
            end
         endcase
      end
   end

   // A new output byte is fetched on the last sampling edge before it is due.
   always_comb begin
      loadTx = 1'b0;
      txByte = `DPD_BLANK_BYTE;
      if (sclkRise && bitCnt == 5'h07) begin
         if (ph == PH_CMD) begin
            loadTx = (nextByteIn == `DPD_CMD_STATUS) && !deepPowerDown && !exitWait;
            txByte = {7'h00, busyFlag};
         end else if (ph == PH_DUMMY || ph == PH_DATA) begin
            loadTx = 1'b1;
            if (cmd == `DPD_CMD_STATUS) begin
               txByte = {7'h00, busyFlag};
            end else begin
               txByte = sfdpByte(ph == PH_DUMMY ? addr : addr + 24'h000001);
            end
         end
      end
   end

   // Output shifter: mode 0, so each bit changes on the falling clock edge.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         txShift <= 8'h00;
         miso <= 1'b0;
         misoOe <= 1'b0;
      end else if (csS2) begin
         misoOe <= 1'b0;
      end else if (loadTx) begin
         txShift <= txByte;
      end else if (sclkFall && ph == PH_DATA) begin
         miso <= txShift[7];
         misoOe <= 1'b1;
         txShift <= {txShift[6:0], 1'b0};
      end
   end

   // Power state acts only when chip select rises after exactly eight bits.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         deepPowerDown <= 1'b0;
         exitWait <= 1'b0;
         waitCnt <= 11'h000;
      end else if (exitWait) begin
         if (waitCnt == 11'h000) begin
            exitWait <= 1'b0;
         end else begin
            waitCnt <= waitCnt - 11'h001;
         end
      end else if (csRise && cmdValid) begin
         if (!deepPowerDown && cmd == `DPD_CMD_ENTER) begin
            deepPowerDown <= 1'b1;
         end else if (deepPowerDown && cmd == `DPD_CMD_EXIT) begin
            deepPowerDown <= 1'b0;
            exitWait <= 1'b1;
            waitCnt <= 11'(`DPD_EXIT_CYCLES - 1);
         end
      end
   end

   assign apbAccess = psel && penable && !pready;

   // Busy flag is set by software standing in for the array controller.
   // The write lands on the edge that completes the transfer, never during the wait state.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busyFlag <= 1'b0;
      end else if (psel && penable && pready && pwrite && paddr == `DPD_REG_CTRL && pstrb[0]) begin
         busyFlag <= pwdata[`DPD_CTRL_BUSY];
      end
   end

   // APB slave: one wait state, answer registered.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= apbAccess;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (apbAccess) begin
            case (paddr)
               `DPD_REG_CTRL: begin
                  prdata[`DPD_CTRL_BUSY] <= busyFlag;
               end
               `DPD_REG_STATUS: begin
                  pslverr <= pwrite;
                  prdata[`DPD_ST_DPD] <= deepPowerDown;
                  prdata[`DPD_ST_EXITWAIT] <= exitWait;
                  prdata[`DPD_ST_BUSY] <= busyFlag;
               end
               `DPD_REG_DESC: begin
                  pslverr <= pwrite;
                  prdata <= `DPD_DESC_WORD;
               end
               default: begin
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // Checks.
   logic descRead;
   assign descRead = apbAccess && !pwrite && paddr == `DPD_REG_DESC;

   // Cycles spent in the exit delay, so its length is checked without a long repetition.
   logic [10:0] exitLen;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         exitLen <= 11'h000;
      end else if (exitWait) begin
         exitLen <= exitLen + 11'h001;
      end else begin
         exitLen <= 11'h000;
      end
   end

   sequence exitTaken_s;
      csRise && cmdValid && deepPowerDown && !exitWait && cmd == `DPD_CMD_EXIT;
   endsequence

   sequence waitHeld_s;
      exitWait [*8];
   endsequence

   sfdp_byte_a: assert property (@(posedge clock) disable iff (!rst_b)
      loadTx && ph == PH_DUMMY && cmd == `DPD_CMD_SFDP && addr == `DPD_BPT_BASE + `DPD_WORD14_OFS
      |=> txShift == 8'hF7)
      else $error("first descriptor byte wrong");
   sfdp_next_a: assert property (@(posedge clock) disable iff (!rst_b)
      loadTx && ph == PH_DATA && cmd == `DPD_CMD_SFDP && addr == `DPD_BPT_BASE + `DPD_WORD14_OFS
      |=> txShift == 8'hBD)
      else $error("second descriptor byte wrong");
   dpd_avail_a: assert property (@(posedge clock) disable iff (!rst_b)
      descRead |=> pready && !prdata[31])
      else $error("feature bit not zero");
   dpd_enter_a: assert property (@(posedge clock) disable iff (!rst_b)
      csRise && cmdValid && !deepPowerDown && !exitWait && cmd == `DPD_CMD_ENTER
      |=> deepPowerDown && !exitWait)
      else $error("enter instruction not obeyed");
   dpd_exit_a: assert property (@(posedge clock) disable iff (!rst_b)
      exitTaken_s |=> !deepPowerDown ##0 waitHeld_s)
      else $error("exit instruction not obeyed");
   desc_codes_a: assert property (@(posedge clock) disable iff (!rst_b)
      descRead |=> prdata[30:23] == 8'hB9 && prdata[22:15] == 8'hAB && prdata[14:13] == 2'b01)
      else $error("descriptor codes wrong");
   exit_time_a: assert property (@(posedge clock) disable iff (!rst_b)
      $fell(exitWait) |-> exitLen == 11'(`DPD_EXIT_CYCLES))
      else $error("exit delay length wrong");
   exit_bound_a: assert property (@(posedge clock) disable iff (!rst_b)
      exitWait |-> exitLen < 11'(`DPD_EXIT_CYCLES))
      else $error("exit delay runs too long");
   poll_field_a: assert property (@(posedge clock) disable iff (!rst_b)
      descRead |=> prdata[3:2] == 2'b01 && prdata[12:8] == 5'b11101)
      else $error("polling field wrong");
   busy_byte_a: assert property (@(posedge clock) disable iff (!rst_b)
      loadTx && ph == PH_CMD |=> txShift == {7'h00, $past(busyFlag)})
      else $error("status byte wrong");
   rsvd_ones_a: assert property (@(posedge clock) disable iff (!rst_b)
      descRead |=> prdata[7:4] == 4'hF && prdata[1:0] == 2'b11)
      else $error("reserved bits not ones");
   ignore_dpd_a: assert property (@(posedge clock) disable iff (!rst_b)
      deepPowerDown && csRise && cmd != `DPD_CMD_EXIT |=> deepPowerDown && !loadTx)
      else $error("instruction obeyed while powered down");

endmodule // dpd_sfdp_power
`default_nettype wire

// ===== dpd_sfdp_power_test.sv
`timescale 1ns/1ns
`default_nettype none
module dpd_sfdp_power_test;
   import dpd_pkg::*;
   logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, toggle = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, d, seed = 32'h3092;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, sclk, csB, mosi, miso, misoOe, misoLine, deepPowerDown, err, oe;
   logic [71:0] rx;
   int errorCnt = 0, checksDone = 0, cycles = 0;
   always #10 clock = ~clock;
   // A released line shows a changing pattern so a stale value cannot pass.
   always @(posedge clock) toggle <= ~toggle;
   assign misoLine = misoOe ? miso : toggle;
   dpd_sfdp_power dut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .sclk, .csB, .mosi, .miso, .misoOe, .deepPowerDown);
   dpd_spi_host host (.clock, .misoLine, .misoOe, .sclk, .csB, .mosi);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] descWord();
      return {1'b0, 8'hB9, 8'hAB, 2'b01, 5'b11101, 4'hF, 2'b01, 2'b11};
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errorCnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic completeRun();
      if (errorCnt == 0 && checksDone > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r,
         output logic e);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 8000) begin
         errorCnt++;
         completeRun();
      end
   end
   initial begin
      d = descWord();
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      repeat (4) @(posedge clock);
      apb(1'b0, 12'h008, 32'h0, rd, err);
      check("desc", rd, d);
      check("present", 32'(rd[31]), 32'h0);
      check("enterCode", 32'(rd[30:23]), 32'hB9);
      check("exitCode", 32'(rd[22:15]), 32'hAB);
      check("unit", 32'(rd[14:13]), 32'h1);
      check("count", 32'(rd[12:8]), 32'h1D);
      check("pollKind", 32'(rd[3:2]), 32'h1);
      check("reserved", 32'({rd[7:4], rd[1:0]}), 32'h3F);
      apb(1'b1, 12'h008, seed, rd, err);
      check("descWrite", 32'(err), 32'h1);
      apb(1'b0, 12'h00C, 32'h0, rd, err);
      check("unmapped", {31'h0, err}, 32'h1);
      host.frame(72, {8'h5A, 24'h0000B4, 40'h0}, rx, oe);
      check("table", rx[31:0], {d[7:0], d[15:8], d[23:16], d[31:24]});
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         apb(1'b1, 12'h000, seed, rd, err);
         host.frame(16, 72'h0500, rx, oe);
         check("poll", 32'(rx[7:0]), {31'h0, seed[0]});
      end
      apb(1'b1, 12'h000, 32'h0, rd, err);
      host.frame(8, 72'hB9, rx, oe);
      check("sleep", 32'(deepPowerDown), 32'h1);
      host.frame(16, 72'h0500, rx, oe);
      check("sleepQuiet", 32'(oe), 32'h0);
      host.frame(8, 72'hAB, rx, oe);
      apb(1'b0, 12'h004, 32'h0, rd, err);
      check("wake", 32'({rd[1:0], deepPowerDown}), 32'h4);
      host.frame(8, 72'hB9, rx, oe);
      check("waitQuiet", 32'(deepPowerDown), 32'h0);
      // The exit delay is 1500 clocks from the end of the exit frame.
      repeat (1300) @(posedge clock);
      apb(1'b0, 12'h004, 32'h0, rd, err);
      check("waitHeld", 32'(rd[1]), 32'h1);
      repeat (150) @(posedge clock);
      apb(1'b0, 12'h004, 32'h0, rd, err);
      check("waitOver", 32'(rd[1]), 32'h0);
      host.frame(16, 72'h0500, rx, oe);
      check("awake", 32'(oe), 32'h1);
      check("awakePoll", 32'(rx[7:0]), 32'h0);
      completeRun();
   end
endmodule // dpd_sfdp_power_test
`default_nettype wire

// ===== dpd_spi_host.sv
`timescale 1ns/1ns
`default_nettype none
module dpd_spi_host (
   // System side.
   input wire logic clock,
   input wire logic misoLine,
   input wire logic misoOe,
   // Link side.
   output var logic sclk,
   output var logic csB,
   output var logic mosi
);
   initial begin
      sclk = 1'b0;
      csB = 1'b1;
      mosi = 1'b0;
   end
   // Mode 0, MSB first; one link period of 160 ns spans eight system clocks.
   task automatic frame(input int n, input logic [71:0] tx, output logic [71:0] rx, output logic oe);
      rx = '0;
      oe = 1'b0;
      @(posedge clock);
      csB <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         mosi <= tx[i];
         repeat (4) @(posedge clock);
         rx = {rx[70:0], misoLine};
         oe = oe | misoOe;
         sclk <= 1'b1;
         repeat (4) @(posedge clock);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge clock);
      csB <= 1'b1;
      repeat (8) @(posedge clock);
   endtask
endmodule // dpd_spi_host
`default_nettype wire
